// ==== design/cnp_pkg.sv ====
/*
  cnp_pkg: register map, field positions, reset values and carrier structs
  for the next-page and gigabit control register slice.
  assumes: included before every design file that uses it.
*/
package cnp_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [3:0] IDX_NP_TX = 4'h7;
  localparam logic [3:0] IDX_LP_NP = 4'h8;
  localparam logic [3:0] IDX_GIG_CTL = 4'h9;
  localparam logic [31:0] ADDR_NP_TX = {26'h000_0000, IDX_NP_TX, 2'b00};
  localparam logic [31:0] ADDR_LP_NP = {26'h000_0000, IDX_LP_NP, 2'b00};
  localparam logic [31:0] ADDR_GIG_CTL = {26'h000_0000, IDX_GIG_CTL, 2'b00};
  // own register: event strobes and live status
  localparam logic [31:0] ADDR_EVT = 32'h0000_0040;

  // next page transmit fields
  localparam int NP_NEXT = 15;
  localparam int NP_RSVD = 14;
  localparam int NP_MSGPG = 13;
  localparam int NP_ACK2 = 12;
  localparam int NP_TOGGLE = 11;
  localparam logic [15:0] NP_TX_RESET = 16'h2001;
  // software writable bits of next page transmit
  localparam logic [15:0] NP_TX_WMASK = 16'hb7ff;

  // gigabit control fields
  localparam int GC_TM_LSB = 13;
  localparam int GC_MS_MAN = 12;
  localparam int GC_MS_VAL = 11;
  localparam int GC_PORT = 10;
  localparam int GC_ADV_FD = 9;
  localparam int GC_ADV_HD = 8;
  localparam logic [15:0] GC_RESET = 16'h0300;
  // bits 12..8 are held pending until an update event
  localparam logic [15:0] GC_PEND_MASK = 16'h1f00;

  // own event register bits (write 1 to pulse)
  localparam int EV_SW_RESET = 0;
  localparam int EV_AN_RESTART = 1;
  localparam int EV_PWR_UP = 2;

  // test mode encodings
  typedef enum logic [2:0] {
    CNP_TM_NORMAL = 3'b000,
    CNP_TM_WAVE = 3'b001,
    CNP_TM_JIT_M = 3'b010,
    CNP_TM_JIT_S = 3'b011,
    CNP_TM_DIST = 3'b100
  } cnp_tm_t;

  // ahb data phase record
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } cnp_dphase_t;

  // settings handed to the negotiation engine
  typedef struct packed {
    logic [2:0] test_mode;
    logic ms_manual;
    logic ms_master;
    logic prefer_master;
    logic adv_fd;
    logic adv_hd;
  } cnp_gig_cfg_t;

endpackage

// ==== design/cnp_gig_ctl.sv ====
/*
  cnp_gig_ctl: gigabit control register with deferred update of bits 12..8.
  assumes: write strobe and data come from the bus slave on the same clock.
*/
`timescale 1ns/1ps
module cnp_gig_ctl (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // software write
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // update events
  input wire logic sw_reset,
  input wire logic an_restart,
  input wire logic pwr_up,
  input wire logic link_fail,
  // register view and effective value
  output logic [15:0] reg_view,
  output logic [15:0] active
);

  logic [15:0] next_view;
  logic [15:0] next_active;
  wire update = sw_reset | an_restart | pwr_up | link_fail;

  // written value; restart clears the test mode field even if written now
  always_comb begin
    next_view = wr_en ? wr_data : reg_view;
    if (an_restart) begin
      next_view[15:13] = 3'b000; // R7
    end
    next_view[7:0] = wr_en ? wr_data[7:0] : reg_view[7:0];
  end

  // test mode and low bits act at once, pending bits only on an update
  always_comb begin
    next_active = (next_view & ~cnp_pkg::GC_PEND_MASK)
      | (active & cnp_pkg::GC_PEND_MASK); // R13
    if (update) begin
      next_active = next_view; // R13
    end
  end

  // both copies reset together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_view <= cnp_pkg::GC_RESET;
      active <= cnp_pkg::GC_RESET;
    end else begin
      reg_view <= next_view;
      active <= next_active;
    end
  end

  a_pend_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    (!sw_reset && !an_restart && !pwr_up && !link_fail)
      |=> (active[12:8] == $past(active[12:8])))
    else $error("pending gigabit bits changed without update");

  a_restart_tm: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    an_restart |=> (reg_view[15:13] == 3'b000))
    else $error("restart did not clear test mode");

  a_update_take: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    link_fail |=> (active[12:8] == reg_view[12:8]))
    else $error("link drop did not apply pending bits");

endmodule // cnp_gig_ctl

// ==== design/cnp_regs.sv ====
/*
  cnp_regs: next page transmit, partner next page and gigabit control
  registers behind an ahb-lite slave.
  assumes: single aligned word transfers; the negotiation engine drives
  the received page, toggle and event strobes synchronously to hclk.
*/
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
// Function
// R1 - write to transmit page flags page loaded
// R2 - link fail resets transmit page register
// R3 - transmit bits map onto code word
// R4 - partner page register read only, in place
// R5 - bits 15:13 select test mode
// R6 - jitter modes take transmit clock from receive
// R7 - negotiation restart clears test mode
// R8 - software resets after leaving test mode
// R9 - bit 12 selects manual master/slave
// R10 - bit 11 picks master or slave
// R11 - port type ignored under manual configuration
// R12 - bits 9,8 advertise gigabit duplex, reset one
// R13 - bits 12..8 held pending until update event
// R14 - toggle comes from engine, never software
module cnp_regs (
  // ahb-lite clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // negotiation engine side
  input wire logic link_fail,
  input wire logic an_restart,
  input wire logic np_sent,
  input wire logic lp_page_valid,
  input wire logic [15:0] lp_page,
  input wire logic np_load_clear,
  output logic np_loaded,
  output logic [15:0] np_tx_word,
  output cnp_pkg::cnp_gig_cfg_t gig_cfg,
  output logic tx_clk_from_rx,
  output logic sw_reset
);

  // data phase captured from the address phase
  cnp_pkg::cnp_dphase_t dph;
  cnp_pkg::cnp_dphase_t next_dph;

  // register contents
  logic [15:0] np_tx;
  logic [15:0] lp_np;
  logic tx_toggle;
  logic [15:0] gc_view;
  logic [15:0] gc_active;

  // address phase decode
  wire addr_take = hsel & hready & htrans[1];
  assign next_dph = '{valid: addr_take, write: hwrite, addr: haddr};

  // data phase write strobes
  wire wr_ok = dph.valid & dph.write;
  wire wr_np = wr_ok & (dph.addr == cnp_pkg::ADDR_NP_TX);
  wire wr_gc = wr_ok & (dph.addr == cnp_pkg::ADDR_GIG_CTL);
  wire wr_ev = wr_ok & (dph.addr == cnp_pkg::ADDR_EVT);
  wire ev_swr = wr_ev & hwdata[cnp_pkg::EV_SW_RESET];
  wire ev_anr = (wr_ev & hwdata[cnp_pkg::EV_AN_RESTART]) | an_restart;
  wire ev_pwr = wr_ev & hwdata[cnp_pkg::EV_PWR_UP];

  // read decode selected in the address phase
  wire rd_np = (haddr == cnp_pkg::ADDR_NP_TX);
  wire rd_lp = (haddr == cnp_pkg::ADDR_LP_NP);
  wire rd_gc = (haddr == cnp_pkg::ADDR_GIG_CTL);
  wire rd_ev = (haddr == cnp_pkg::ADDR_EVT);
  wire [15:0] np_view = {np_tx[15], 1'b0, np_tx[13:12], tx_toggle, np_tx[10:0]}; // R3 R14
  wire [15:0] ev_view = {13'h0000, np_loaded, tx_clk_from_rx, 1'b0};
  wire [15:0] rd_sel = rd_np ? np_view
    : rd_lp ? lp_np // R4
    : rd_gc ? gc_view
    : rd_ev ? ev_view
    : 16'h0000;

  // next transmit page: link fail wins, then software write
  wire [15:0] next_np_tx = link_fail ? cnp_pkg::NP_TX_RESET // R2
    : wr_np ? (hwdata[15:0] & cnp_pkg::NP_TX_WMASK) // R3
    : np_tx;

  // jitter modes take clock from the receive pin
  wire [2:0] tm_next = gc_active[15:13];
  wire next_tx_clk = (tm_next == cnp_pkg::CNP_TM_JIT_M)
    | (tm_next == cnp_pkg::CNP_TM_JIT_S); // R5 R6

  // port type meaningless under manual configuration
  wire prefer_eff = gc_active[cnp_pkg::GC_MS_MAN] ? 1'b0
    : gc_active[cnp_pkg::GC_PORT]; // R11
  wire cnp_pkg::cnp_gig_cfg_t next_cfg = '{
    test_mode: gc_active[15:13], // R5
    ms_manual: gc_active[cnp_pkg::GC_MS_MAN], // R9
    ms_master: gc_active[cnp_pkg::GC_MS_MAN] & gc_active[cnp_pkg::GC_MS_VAL], // R10
    prefer_master: prefer_eff,
    adv_fd: gc_active[cnp_pkg::GC_ADV_FD], // R12
    adv_hd: gc_active[cnp_pkg::GC_ADV_HD] // R12
  };

  // page loaded flag: set by write wins over clear
  wire next_loaded = wr_np ? 1'b1 // R1
    : (np_load_clear | link_fail) ? 1'b0
    : np_loaded;

  // gigabit control with deferred update
  cnp_gig_ctl u_gig (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_gc),
    .wr_data(hwdata[15:0]),
    .sw_reset(ev_swr),
    .an_restart(ev_anr),
    .pwr_up(ev_pwr),
    .link_fail(link_fail),
    .reg_view(gc_view),
    .active(gc_active)
  );

  // bus slave: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dph <= next_dph;
      hrdata <= {16'h0000, rd_sel};
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // transmit page and loaded flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      np_tx <= cnp_pkg::NP_TX_RESET;
      np_loaded <= 1'b0;
    end else begin
      np_tx <= next_np_tx;
      np_loaded <= next_loaded;
    end
  end

  // toggle alternates on each sent page, restarts on link fail
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_toggle <= 1'b0;
    end else if (link_fail) begin
      tx_toggle <= 1'b0; // R2
    end else if (np_sent) begin
      tx_toggle <= ~tx_toggle; // R14
    end
  end

  // partner page captured as received
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lp_np <= 16'h0000;
    end else if (lp_page_valid) begin
      lp_np <= lp_page; // R4
    end
  end

  // outputs to the engine, all registered
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      np_tx_word <= cnp_pkg::NP_TX_RESET;
      gig_cfg <= '0;
      tx_clk_from_rx <= 1'b0;
      sw_reset <= 1'b0;
    end else begin
      np_tx_word <= {next_np_tx[15], 1'b0, next_np_tx[13:12], tx_toggle,
        next_np_tx[10:0]}; // R3
      gig_cfg <= next_cfg;
      tx_clk_from_rx <= next_tx_clk; // R6
      sw_reset <= ev_swr; // R8
    end
  end

  // assertions
  a_write_loads: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    wr_np |=> np_loaded)
    else $error("transmit write did not flag page loaded");

  a_link_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    link_fail |=> (np_tx == cnp_pkg::NP_TX_RESET) && (np_loaded == $past(wr_np)))
    else $error("link fail did not clear transmit page");

  a_tx_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    np_tx_word[cnp_pkg::NP_RSVD] == 1'b0)
    else $error("reserved transmit bit set");

  a_lp_capture: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    lp_page_valid |=> lp_np == $past(lp_page))
    else $error("partner page not captured");

  a_jitter_clk: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    (gc_active[15:13] == 3'b010 || gc_active[15:13] == 3'b011) |=> tx_clk_from_rx)
    else $error("jitter mode did not select receive clock");

  a_manual_port: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    gc_active[cnp_pkg::GC_MS_MAN] |=> !gig_cfg.prefer_master)
    else $error("port type used under manual configuration");

  a_toggle_flip: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    (np_sent && !link_fail) |=> tx_toggle != $past(tx_toggle))
    else $error("toggle did not alternate");

  a_sw_toggle: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    (wr_np && !np_sent && !link_fail) |=> $stable(tx_toggle))
    else $error("software write moved toggle");

  a_master_cfg: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    (gc_active[12:11] == 2'b11) |=> gig_cfg.ms_master)
    else $error("manual master not passed on");

endmodule // cnp_regs

// ==== tb/cnp_engine_model.sv ====
/*
  cnp_engine_model: negotiation engine and link partner stand-in.
  assumes: its tasks are called by the bench, in step with hclk.
*/
`timescale 1ns/1ps
module cnp_engine_model (
  // clock
  input wire logic hclk,
  // engine strobes
  output logic np_sent,
  output logic np_load_clear,
  output logic link_fail,
  output logic an_restart,
  // received code word
  output logic lp_page_valid,
  output logic [15:0] lp_page
);
  // quiet lines at time zero
  initial begin
    {np_sent, np_load_clear, link_fail, an_restart, lp_page_valid} = 5'b00000;
    lp_page = 16'h5a5a;
  end
  // strobe: 0 page sent, 1 page consumed, 2 link down, 3 restart
  task automatic pulse(input int which);
    @(posedge hclk);
    case (which)
      0: np_sent <= 1'b1;
      1: np_load_clear <= 1'b1;
      2: link_fail <= 1'b1;
      default: an_restart <= 1'b1;
    endcase
    @(posedge hclk);
    {np_sent, np_load_clear, link_fail, an_restart} <= 4'b0000;
  endtask
  // one-cycle page, then the word lines wander
  task automatic give_page(input logic [15:0] w);
    @(posedge hclk);
    lp_page <= w;
    lp_page_valid <= 1'b1;
    @(posedge hclk);
    lp_page <= ~w;
    lp_page_valid <= 1'b0;
  endtask
endmodule // cnp_engine_model

// ==== tb/tb_top.sv ====
/*
  tb_top: self-checking bench for cnp_regs.
  assumes: one ahb-lite slave, hready fed from hreadyout.
*/
`timescale 1ns/1ps
module tb_top;
  // bus side
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  // engine side
  logic link_fail, an_restart, np_sent, lp_page_valid, np_load_clear;
  logic np_loaded, tx_clk_from_rx, sw_reset;
  logic [15:0] lp_page, np_tx_word;
  cnp_pkg::cnp_gig_cfg_t gig_cfg;
  // bookkeeping
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h0001_67ef;

  always #25 hclk = ~hclk;

  cnp_regs dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hreadyout),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .link_fail(link_fail),
    .an_restart(an_restart),
    .np_sent(np_sent),
    .lp_page_valid(lp_page_valid),
    .lp_page(lp_page),
    .np_load_clear(np_load_clear),
    .np_loaded(np_loaded),
    .np_tx_word(np_tx_word),
    .gig_cfg(gig_cfg),
    .tx_clk_from_rx(tx_clk_from_rx),
    .sw_reset(sw_reset)
  );
  cnp_engine_model eng (
    .hclk(hclk),
    .np_sent(np_sent),
    .np_load_clear(np_load_clear),
    .link_fail(link_fail),
    .an_restart(an_restart),
    .lp_page_valid(lp_page_valid),
    .lp_page(lp_page)
  );

  // xorshift stimulus source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // settings expected once a written word takes effect
  function automatic logic [7:0] cfg_exp(input logic [15:0] v);
    // role only means something under manual configuration
    return {3'b000, v[12], v[11] & v[12], v[10] & ~v[12], v[9], v[8]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one single word transfer; read data taken at the data phase edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    // the slave always answers okay
    chk(hresp, 1'b0);
  endtask
  task automatic settle();
    repeat (3) @(posedge hclk);
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    logic [31:0] r, v;
    logic [15:0] ew;
    logic [7:0] cur;
    logic tog;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // reset contents
    xfer(1'b0, cnp_pkg::ADDR_NP_TX, '0, r);
    chk(r, 32'h0000_2001);
    xfer(1'b0, cnp_pkg::ADDR_LP_NP, '0, r);
    chk(r, 32'h0000_0000);
    xfer(1'b0, cnp_pkg::ADDR_GIG_CTL, '0, r);
    chk(r, 32'h0000_0300);
    chk(gig_cfg, 32'h0000_0003);
    // transmit page load, send and consume
    tog = 1'b0;
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'hffff_ffff : rnd();
      xfer(1'b1, cnp_pkg::ADDR_NP_TX, v, r);
      settle();
      chk(np_loaded, 1'b1);
      // loaded flag is also visible in the event register
      xfer(1'b0, cnp_pkg::ADDR_EVT, '0, r);
      chk(r, 32'h0000_0004);
      ew = (v[15:0] & cnp_pkg::NP_TX_WMASK) | {4'h0, tog, 11'h000};
      chk(np_tx_word, ew);
      xfer(1'b0, cnp_pkg::ADDR_NP_TX, '0, r);
      chk(r, {16'h0000, ew});
      eng.pulse(0);
      tog = ~tog;
      eng.pulse(1);
      settle();
      chk(np_tx_word[11], tog);
      chk(np_loaded, 1'b0);
    end
    // link drop wipes the transmit page
    eng.pulse(2);
    settle();
    chk(np_tx_word, 32'h0000_2001);
    // received pages; writes there are ignored
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 32'h0000_ffff : rnd();
      eng.give_page(v[15:0]);
      xfer(1'b1, cnp_pkg::ADDR_LP_NP, ~v, r);
      xfer(1'b0, cnp_pkg::ADDR_LP_NP, '0, r);
      chk(r, {16'h0000, v[15:0]});
    end
    // unmapped place
    xfer(1'b1, 32'h0000_0050, v, r);
    xfer(1'b0, 32'h0000_0050, '0, r);
    chk(r, 32'h0000_0000);
    // every test mode code
    for (int t = 0; t < 5; t++) begin
      xfer(1'b1, cnp_pkg::ADDR_GIG_CTL, {16'h0000, t[2:0], 13'h0300}, r);
      settle();
      chk(gig_cfg.test_mode, t[2:0]);
      chk(tx_clk_from_rx, (t == 2 || t == 3));
    end
    // restart by engine line, then by event register
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, cnp_pkg::ADDR_GIG_CTL, 32'h0000_6300, r);
      settle();
      if (k == 0) eng.pulse(3);
      else xfer(1'b1, cnp_pkg::ADDR_EVT, 32'h0000_0002, r);
      settle();
      chk(gig_cfg.test_mode, 3'b000);
      chk(tx_clk_from_rx, 1'b0);
      xfer(1'b0, cnp_pkg::ADDR_GIG_CTL, '0, r);
      chk(r[15:13], 3'b000);
    end
    xfer(1'b1, cnp_pkg::ADDR_EVT, 32'h0000_0001, r);
    // software reset strobe stands for exactly one cycle
    @(posedge hclk);
    chk(sw_reset, 1'b1);
    @(posedge hclk);
    chk(sw_reset, 1'b0);
    // deferred bits under each update event
    cur = 8'h03;
    for (int e = 0; e < 4; e++) begin
      v = (e == 0) ? 32'h0000_1c00 : (rnd() & 32'h0000_1f00);
      xfer(1'b1, cnp_pkg::ADDR_GIG_CTL, v, r);
      settle();
      chk(gig_cfg, cur);
      xfer(1'b0, cnp_pkg::ADDR_GIG_CTL, '0, r);
      chk(r, v);
      if (e == 3) eng.pulse(2);
      else xfer(1'b1, cnp_pkg::ADDR_EVT, 32'h1 << e, r);
      settle();
      cur = cfg_exp(v[15:0]);
      chk(gig_cfg, cur);
    end
    wrap_up();
  end
endmodule // tb_top
